/* design/wtu_pkg.sv */
`default_nettype none

package wtu_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CFG   = 8'h04;
    localparam logic [7:0] ADDR_CAUSE = 8'h08;
    localparam logic [7:0] ADDR_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ   = 8'h10;
    localparam logic [7:0] ADDR_MASK  = 8'h14;
    localparam logic [7:0] ADDR_CNT   = 8'h18;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int         CTRL_EN_POS  = 0;
    localparam int         CTRL_PS_LSB  = 1;
    localparam int         CTRL_PS_MSB  = 5;
    localparam logic [4:0] PERIOD_RST   = 5'h0B;
    localparam logic       SWEN_RST     = 1'h0;
    localparam logic [1:0] MODE_RST     = 2'h3;
    localparam logic [4:0] PERIOD_MAX   = 5'h12;
    localparam int         CNT_W        = 24;
    localparam logic [23:0] LIMIT_MIN   = 24'h000020;
    localparam int         LFOSC_KHZ    = 31;
    localparam int         IRQ_WAKE     = 0;
    localparam int         IRQ_RST      = 1;
    localparam logic [1:0] IRQ_RST_VAL  = 2'h0;
    localparam logic [1:0] MASK_RST_VAL = 2'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_SW      = 2'b01,
        MODE_NOSLEEP = 2'b10,
        MODE_ON      = 2'b11
    } wtu_mode_t;

    typedef struct packed {
        logic [4:0] period;
        logic       swEn;
    } wtu_ctrl_t;

    typedef struct packed {
        logic kick;
        logic asleep;
        logic oscFail;
        logic ostRunning;
        logic otherReset;
    } wtu_core_t;

    typedef struct packed {
        wtu_ctrl_t          ctrl;
        wtu_mode_t          mode;
        logic [CNT_W-1:0]   cnt;
        logic               flagN;
        logic               toN;
        logic               pdN;
        logic [1:0]         irqSt;
        logic [1:0]         irqMask;
        logic [2:0]         lfSync;
        logic               lfStable;
        logic               asleepPrev;
        logic [31:0]        prdata;
        logic               slverr;
        logic               wdtRst;
        logic               wake;
    } wtu_state_t;

endpackage

`default_nettype wire

/* design/wtu_top.sv */
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module wtu_top (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              lowFreqOsc,
    input  wire wtu_pkg::wtu_core_t core,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   wdtResetReq,
    output logic                   wakeReq,
    output logic                   timeoutStatusN,
    output logic                   powerdownStatusN,
    output logic                   irq
);

    wtu_pkg::wtu_state_t st_r;
    wtu_pkg::wtu_state_t st_nxt;

    logic                      lfNew;
    logic                      tick;
    logic                      active;
    logic                      clearCnt;
    logic                      hit;
    logic                      sleepEnter;
    logic                      sleepExit;
    logic [wtu_pkg::CNT_W-1:0] limit;
    logic [wtu_pkg::CNT_W-1:0] cntInc;
    logic                      wrEn;
    logic                      rdSetup;
    logic                      mapped;
    logic [31:0]               rdVal;

    // ****************************************
    // low-frequency time base
    // ****************************************
    // stage 2 and 3 must agree before a level change is believed
    always_comb begin
        lfNew = st_r.lfStable;
        if (st_r.lfSync[1] == st_r.lfSync[2]) begin
            lfNew = st_r.lfSync[2];
        end
    end
    assign tick = lfNew & ~st_r.lfStable;

    // ****************************************
    // mode and clearing
    // ****************************************
    assign sleepEnter = core.asleep & ~st_r.asleepPrev;
    assign sleepExit  = ~core.asleep & st_r.asleepPrev;

    always_comb begin
        unique case (st_r.mode)
            wtu_pkg::MODE_ON:      active = 1'b1;
            wtu_pkg::MODE_NOSLEEP: active = ~core.asleep;
            wtu_pkg::MODE_SW:      active = st_r.ctrl.swEn;
            wtu_pkg::MODE_OFF:     active = 1'b0;
        endcase
    end

    // the oscillator divider is not an input at all, so it cannot disturb
    // the count
    assign clearCnt = ~active
                    | core.kick | core.oscFail
                    | core.otherReset
                    | sleepEnter | sleepExit
                    | core.ostRunning;

    // reserved codes fall back to the shortest interval
    always_comb begin
        if (st_r.ctrl.period > wtu_pkg::PERIOD_MAX) begin
            limit = wtu_pkg::LIMIT_MIN;
        end else begin
            limit = wtu_pkg::LIMIT_MIN << st_r.ctrl.period;
        end
    end

    assign cntInc = st_r.cnt + 24'h000001;
    assign hit    = tick & ~clearCnt & (cntInc == limit);

    // ****************************************
    // register access
    // ****************************************
    always_comb begin
        mapped = 1'b1;
        rdVal  = 32'h00000000;
        unique case (paddr)
            wtu_pkg::ADDR_CTRL:  rdVal[5:0] = st_r.ctrl;
            wtu_pkg::ADDR_CFG:   rdVal[1:0] = st_r.mode;
            wtu_pkg::ADDR_CAUSE: rdVal[0]   = st_r.flagN;
            wtu_pkg::ADDR_STAT:  rdVal[1:0] = {st_r.toN, st_r.pdN};
            wtu_pkg::ADDR_IRQ:   rdVal[1:0] = st_r.irqSt;
            wtu_pkg::ADDR_MASK:  rdVal[1:0] = st_r.irqMask;
            wtu_pkg::ADDR_CNT:   rdVal[23:0] = st_r.cnt;
            default:             mapped = 1'b0;
        endcase
    end

    assign rdSetup = psel & ~penable & ~pwrite;
    assign wrEn    = psel & penable & pwrite & st_r.slverr == 1'b0;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt            = st_r;
        st_nxt.lfSync     = {st_r.lfSync[1:0], lowFreqOsc};
        st_nxt.lfStable   = lfNew;
        st_nxt.asleepPrev = core.asleep;
        st_nxt.wdtRst     = 1'b0;
        st_nxt.wake       = 1'b0;

        if (psel & ~penable) begin
            st_nxt.slverr = ~mapped;
        end
        if (rdSetup) begin
            st_nxt.prdata = rdVal;
        end

        if (wrEn) begin
            unique case (paddr)
                wtu_pkg::ADDR_CTRL: begin
                    st_nxt.ctrl.period =
                        pwdata[wtu_pkg::CTRL_PS_MSB:wtu_pkg::CTRL_PS_LSB];
                    st_nxt.ctrl.swEn = pwdata[wtu_pkg::CTRL_EN_POS];
                end
                wtu_pkg::ADDR_CFG: begin
                    st_nxt.mode = wtu_pkg::wtu_mode_t'(pwdata[1:0]);
                end
                wtu_pkg::ADDR_CAUSE: begin
                    st_nxt.flagN = st_r.flagN | pwdata[0];
                end
                wtu_pkg::ADDR_IRQ: begin
                    st_nxt.irqSt = st_r.irqSt & ~pwdata[1:0];
                end
                wtu_pkg::ADDR_MASK: begin
                    st_nxt.irqMask = pwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        if (core.kick) begin
            st_nxt.toN = 1'b1;
            st_nxt.pdN = 1'b1;
        end
        if (sleepEnter) begin
            st_nxt.toN = 1'b1;
            st_nxt.pdN = 1'b0;
        end

        if (clearCnt) begin
            st_nxt.cnt = '0;
        end else if (hit) begin
            st_nxt.cnt = '0;
        end else if (tick) begin
            st_nxt.cnt = cntInc;
        end

        if (hit) begin
            st_nxt.toN = 1'b0;
            if (core.asleep) begin
                st_nxt.wake = 1'b1;
                st_nxt.irqSt[wtu_pkg::IRQ_WAKE] = 1'b1;
            end else begin
                // own reset: clears the counter and reloads control
                st_nxt.wdtRst = 1'b1;
                st_nxt.flagN  = 1'b0;
                st_nxt.irqSt[wtu_pkg::IRQ_RST] = 1'b1;
                st_nxt.ctrl.period = wtu_pkg::PERIOD_RST;
                st_nxt.ctrl.swEn   = wtu_pkg::SWEN_RST;
            end
        end
        if (core.otherReset) begin
            st_nxt.ctrl.period = wtu_pkg::PERIOD_RST;
            st_nxt.ctrl.swEn   = wtu_pkg::SWEN_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r.ctrl.period <= wtu_pkg::PERIOD_RST;
            st_r.ctrl.swEn   <= wtu_pkg::SWEN_RST;
            st_r.mode        <= wtu_pkg::wtu_mode_t'(wtu_pkg::MODE_RST);
            st_r.cnt         <= '0;
            st_r.flagN       <= 1'b1;
            st_r.toN         <= 1'b1;
            st_r.pdN         <= 1'b1;
            st_r.irqSt       <= wtu_pkg::IRQ_RST_VAL;
            st_r.irqMask     <= wtu_pkg::MASK_RST_VAL;
            st_r.lfSync      <= 3'h0;
            st_r.lfStable    <= 1'b0;
            st_r.asleepPrev  <= 1'b0;
            st_r.prdata      <= 32'h00000000;
            st_r.slverr      <= 1'b0;
            st_r.wdtRst      <= 1'b0;
            st_r.wake        <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // zero wait states: the answer is ready in every access cycle
    assign pready           = 1'b1;
    assign prdata           = st_r.prdata;
    assign pslverr          = psel & penable & st_r.slverr;
    assign wdtResetReq      = st_r.wdtRst;
    assign wakeReq          = st_r.wake;
    assign timeoutStatusN   = st_r.toN;
    assign powerdownStatusN = st_r.pdN;
    assign irq              = |(st_r.irqSt & st_r.irqMask);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_ALWAYS_ON: assert property (
        (st_r.mode == wtu_pkg::MODE_ON) && tick && !clearCnt && !hit
        |=> st_r.cnt == $past(st_r.cnt) + 24'h000001)
        else $error("always-on mode did not count");

    AST_SLEEP_OFF: assert property (
        (st_r.mode == wtu_pkg::MODE_NOSLEEP) && core.asleep
        |=> st_r.cnt == '0)
        else $error("counter ran in sleep with sleep-off mode");

    AST_DISABLED: assert property (
        (st_r.mode == wtu_pkg::MODE_OFF)
        || (st_r.mode == wtu_pkg::MODE_SW && !st_r.ctrl.swEn)
        |=> st_r.cnt == '0)
        else $error("counter not held clear while disabled");

    AST_KICK: assert property (
        core.kick |=> st_r.cnt == '0 && st_r.toN && st_r.pdN)
        else $error("kick did not clear the counter");

    AST_RESERVED: assert property (
        st_r.ctrl.period > wtu_pkg::PERIOD_MAX |-> limit == 24'h000020)
        else $error("reserved period code not at minimum");

    AST_RST_VAL: assert property (
        $fell(srst) |-> st_r.ctrl.period == 5'h0B && !st_r.ctrl.swEn
        && st_r.cnt == '0)
        else $error("control not at reset value");

    AST_OST: assert property (
        core.ostRunning [*2] |=> st_r.cnt == '0)
        else $error("counter moved while start-up timer ran");

    AST_SLEEP_WAKE: assert property (
        hit && core.asleep
        |=> wakeReq && !wdtResetReq && !timeoutStatusN ##1 !wakeReq)
        else $error("sleep time-out did not wake cleanly");

    AST_AWAKE_RST: assert property (
        hit && !core.asleep
        |=> wdtResetReq && !st_r.flagN && st_r.ctrl.period == 5'h0B)
        else $error("awake time-out did not reset");

    AST_RD_ZERO: assert property (
        rdSetup && paddr == wtu_pkg::ADDR_CTRL
        |=> prdata[31:6] == 26'h0000000)
        else $error("unimplemented control bits not zero");

    AST_PERIOD_TOP: assert property (
        st_r.ctrl.period == wtu_pkg::PERIOD_MAX |-> limit == 24'h800000)
        else $error("longest period code not at full prescale");

    AST_SW_ON: assert property (
        (st_r.mode == wtu_pkg::MODE_SW) && st_r.ctrl.swEn && tick
        && !clearCnt && !hit |=> st_r.cnt == $past(st_r.cnt) + 24'h000001)
        else $error("software mode with enable did not count");

    AST_SLEEP_ENTRY: assert property (
        sleepEnter |=> st_r.cnt == '0 && !st_r.pdN && st_r.toN)
        else $error("sleep entry did not clear counter and status");

    AST_WAKE_CLEAR: assert property (
        sleepExit |=> st_r.cnt == '0)
        else $error("wake did not clear the counter");

    AST_OSC_FAIL: assert property (
        core.oscFail |=> st_r.cnt == '0)
        else $error("oscillator failure did not clear the counter");

    AST_OTHER_RST: assert property (
        core.otherReset |=> st_r.ctrl.period == 5'h0B && !st_r.ctrl.swEn)
        else $error("device reset did not reload control");

    // a held request would reset the device again and again
    AST_RST_PULSE: assert property (
        wdtResetReq |=> !wdtResetReq)
        else $error("reset request longer than one cycle");

    COV_WAKE:  cover property (hit && core.asleep);
    COV_SLEEP_RUN: cover property (core.asleep && tick && !clearCnt);
    COV_RESET: cover property (hit && !core.asleep);
    COV_KICK:  cover property (core.kick && st_r.cnt != '0);
    COV_ERR:   cover property (pslverr);

endmodule

`default_nettype wire

/* verif/watchdog_timer_unit_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer_unit_bench;

    logic               clk;
    logic               srst;
    logic               lowFreqOsc;
    wtu_pkg::wtu_core_t core;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               wdtResetReq;
    logic               wakeReq;
    logic               timeoutStatusN;
    logic               powerdownStatusN;
    logic               irq;
    logic [31:0]        rd;
    logic               err;
    int                 miscompares;
    int                 compares;
    int                 rstSeen;
    int                 wakeSeen;

    wtu_top DUT (
        .clk(clk), .srst(srst), .lowFreqOsc(lowFreqOsc), .core(core),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdtResetReq(wdtResetReq), .wakeReq(wakeReq),
        .timeoutStatusN(timeoutStatusN),
        .powerdownStatusN(powerdownStatusN), .irq(irq)
    );

    always #2 clk = ~clk;

    // one-cycle requests are counted, so none slips by between reads
    always @(posedge clk) begin
        if (!srst && wdtResetReq === 1'b1) rstSeen++;
        if (!srst && wakeReq === 1'b1) wakeSeen++;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: the watchdog process ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // each tick is slow enough to pass the synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            lowFreqOsc <= 1'b1;
            repeat (8) @(posedge clk);
            lowFreqOsc <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask

    task automatic pulse(input int bitPos);
        core <= wtu_pkg::wtu_core_t'(5'h01 << bitPos);
        @(posedge clk);
        core <= '0;
        repeat (2) @(posedge clk);
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        end_of_test;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        lowFreqOsc = 1'b0;
        core = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {miscompares, compares, rstSeen, wakeSeen} = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdchk("ctrl", wtu_pkg::ADDR_CTRL, 32'h00000016);
        rdchk("mode", wtu_pkg::ADDR_CFG, 32'h00000003);
        rdchk("cause", wtu_pkg::ADDR_CAUSE, 32'h00000001);
        rdchk("stat", wtu_pkg::ADDR_STAT, 32'h00000003);
        apb(1'b1, wtu_pkg::ADDR_CTRL, 32'hFFFFFFFF);
        rdchk("ctrl", wtu_pkg::ADDR_CTRL, 32'h0000003F);
        rdchk("unmapped", 8'h40, 32'h00000000);
        check("slverr", 32'(err), 32'h1);
        // always-on mode ignores the enable bit; shortest period
        apb(1'b1, wtu_pkg::ADDR_CTRL, 32'h0);
        tick(31);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd31);
        check("rst", 32'(rstSeen), 32'd0);
        tick(1);
        check("rst", 32'(rstSeen), 32'd1);
        check("toN", 32'(timeoutStatusN), 32'h0);
        rdchk("cause", wtu_pkg::ADDR_CAUSE, 32'h0);
        rdchk("ctrl", wtu_pkg::ADDR_CTRL, 32'h00000016);
        rdchk("irqst", wtu_pkg::ADDR_IRQ, 32'h2);
        apb(1'b1, wtu_pkg::ADDR_MASK, 32'h2);
        check("irq", 32'(irq), 32'h1);
        apb(1'b1, wtu_pkg::ADDR_IRQ, 32'h2);
        check("irq", 32'(irq), 32'h0);
        // kick, oscillator failure and other reset all clear the count
        for (int i = 0; i < 5; i += 2) begin
            apb(1'b1, wtu_pkg::ADDR_CTRL, 32'h0);
            tick(5);
            rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd5);
            pulse(4 - i);
            rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd0);
        end
        rdchk("ctrl", wtu_pkg::ADDR_CTRL, 32'h00000016);
        apb(1'b1, wtu_pkg::ADDR_CTRL, 32'h0);
        core.ostRunning <= 1'b1;
        tick(4);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd0);
        core.ostRunning <= 1'b0;
        tick(2);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd2);
        // mode / enable table over off and software modes: only software mode with enable counts
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, wtu_pkg::ADDR_CFG, 32'(m >> 1));
            apb(1'b1, wtu_pkg::ADDR_CTRL, 32'(m & 1));
            pulse(4);
            tick(3);
            rdchk("cnt", wtu_pkg::ADDR_CNT, (m == 3) ? 32'd3 : 32'd0);
        end
        apb(1'b1, wtu_pkg::ADDR_CFG, 32'h2);
        pulse(4);
        core.asleep <= 1'b1;
        tick(3);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd0);
        core.asleep <= 1'b0;
        tick(2);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd2);
        // reserved period code must behave as the 1:32 minimum
        apb(1'b1, wtu_pkg::ADDR_CFG, 32'h3);
        apb(1'b1, wtu_pkg::ADDR_CTRL, 32'h3E);
        apb(1'b1, wtu_pkg::ADDR_MASK, 32'h1);
        core.asleep <= 1'b1;
        tick(5);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd5);
        core.asleep <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk("cnt", wtu_pkg::ADDR_CNT, 32'd0);
        core.asleep <= 1'b1;
        tick(31);
        check("wake", 32'(wakeSeen), 32'd0);
        tick(1);
        check("wake", 32'(wakeSeen), 32'd1);
        check("rst", 32'(rstSeen), 32'd1);
        rdchk("stat", wtu_pkg::ADDR_STAT, 32'h0);
        check("irq", 32'(irq), 32'h1);
        end_of_test;
    end

endmodule

`default_nettype wire
